// file: qawd_control_status.sv
// Watchdog mode control, question configuration and error flags
//
// Overview of operation
// - Hold set keeps Long Window; clear lets it expire
// - Mode select: 0 trigger, 1 Q&A; locked
// - Return bit re-enters Long Window after sequence
// - Feedback bits 7:6, Long Window writes only
// - LFSR select bits 5:4, Long Window writes only
// - Seed bits 3:0 reset 1010b, locked
// - Reset flag bit 7 on threshold-sum warm reset
// - Fail flag bit 6 when drive enable cleared
// - Wrong answer flag bit 5 in Q&A
// - Answer order flag bit 4 in Q&A
// - Early answer flag bit 3: final in window 1
// - Early trigger flag bit 2: trigger in window 1
// - Timeout flag bit 1 on unserviced sequence
// - Unserviced Long Window expiry: warm reset, flag bit 0
// - Flags clear by writing one, reset zero
// - Clear drive enable, warm reset past thresholds
`timescale 1ns/1ns
`include "qawd_regs.svh"
module qawd_control_status
    import qawd_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // Register port
    input  wire logic                    reg_wr_en,
    input  wire logic                    reg_rd_en,
    input  wire logic [`QAWD_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]              reg_wdata,
    output logic [7:0]                   reg_rdata,
    // Window durations
    input  wire logic [7:0]              long_win_cfg,
    input  wire logic [6:0]              win1_cfg,
    input  wire logic [6:0]              win2_cfg,
    // Fail counter and thresholds
    input  wire logic [3:0]              failure_counter,
    input  wire logic [2:0]              first_fail_threshold,
    input  wire logic [2:0]              second_fail_threshold,
    input  wire logic                    warm_reset_allow,
    // Servicing events
    input  wire logic                    trigger_pin,
    input  wire logic                    answer_byte_pulse,
    input  wire logic                    answer_byte_match,
    // Configuration out
    output logic                         long_window_hold,
    output logic                         trigger_or_qa_select,
    output logic                         return_to_long_window,
    output logic [1:0]                   question_feedback_cfg,
    output logic [1:0]                   question_lfsr_select,
    output logic [3:0]                   question_seed,
    // Watchdog status out
    output logic                         in_long_window,
    output logic [1:0]                   answer_count,
    output logic                         seq_good_pulse,
    output logic                         seq_bad_pulse,
    output logic                         output_drive_enable_clear,
    output logic                         warm_reset_req
);

    // Reset release
    logic rst_s1;
    logic rst_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // Trigger pin edge
    logic trig_s;
    logic trig_d;
    logic trig_rise;

    qawd_sync u_trig_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (trigger_pin),
        .q     (trig_s)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_d <= 1'b0;
        end else begin
            trig_d <= trig_s;
        end
    end

    assign trig_rise = trig_s & ~trig_d;

    // Register storage
    logic [7:0]  mode_reg;
    logic [7:0]  qcfg_reg;
    logic [7:0]  err_flags;
    logic [7:0]  next_mode_reg;
    logic [7:0]  next_qcfg_reg;
    logic [7:0]  next_err_flags;
    logic [7:0]  next_rdata;
    logic [7:0]  flag_set;
    logic [7:0]  flag_clr;
    logic        wr_mode;
    logic        wr_qcfg;
    logic        wr_err;
    qawd_state_t state;
    logic        in_lw;

    assign in_lw   = (state == QAWD_LONG_WIN);
    assign wr_mode = reg_wr_en && (reg_addr == `QAWD_MODE_OFS);
    assign wr_qcfg = reg_wr_en && (reg_addr == `QAWD_QCFG_OFS);
    assign wr_err  = reg_wr_en && (reg_addr == `QAWD_ERR_OFS);

    always_comb begin
        next_mode_reg = mode_reg;
        next_qcfg_reg = qcfg_reg;
        if (wr_mode) begin
            next_mode_reg[`QAWD_RSV_MSB:`QAWD_RSV_LSB] =
                reg_wdata[`QAWD_RSV_MSB:`QAWD_RSV_LSB];
            next_mode_reg[`QAWD_HOLD_BIT] = reg_wdata[`QAWD_HOLD_BIT];
            next_mode_reg[`QAWD_RET_BIT] = reg_wdata[`QAWD_RET_BIT];
            if (in_lw) begin
                next_mode_reg[`QAWD_SEL_BIT] = reg_wdata[`QAWD_SEL_BIT];
            end
        end
        // Question setup only changes inside the Long Window
        if (wr_qcfg && in_lw) begin
            next_qcfg_reg = reg_wdata;
        end
        flag_clr       = wr_err ? reg_wdata : 8'h00;
        next_err_flags = (err_flags & ~flag_clr) | flag_set;
        case (reg_addr)
            `QAWD_MODE_OFS: next_rdata = mode_reg;
            `QAWD_QCFG_OFS: next_rdata = qcfg_reg;
            `QAWD_ERR_OFS:  next_rdata = err_flags;
            default:        next_rdata = 8'h00;
        endcase
        if (!reg_rd_en) begin
            next_rdata = reg_rdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg  <= `QAWD_MODE_RST;
            qcfg_reg  <= `QAWD_QCFG_RST;
            err_flags <= `QAWD_ERR_RST;
            reg_rdata <= 8'h00;
        end else begin
            mode_reg  <= next_mode_reg;
            qcfg_reg  <= next_qcfg_reg;
            err_flags <= next_err_flags;
            reg_rdata <= next_rdata;
        end
    end

    // Configuration outputs follow their register bits
    always_comb begin
        long_window_hold      = mode_reg[`QAWD_HOLD_BIT];
        trigger_or_qa_select  = mode_reg[`QAWD_SEL_BIT];
        return_to_long_window = mode_reg[`QAWD_RET_BIT];
        question_feedback_cfg = qcfg_reg[`QAWD_FDBK_MSB:`QAWD_FDBK_LSB];
        question_lfsr_select  = qcfg_reg[`QAWD_LFSR_MSB:`QAWD_LFSR_LSB];
        question_seed         = qcfg_reg[`QAWD_SEED_MSB:`QAWD_SEED_LSB];
    end

    // Window sequencing
    qawd_state_t next_state;
    logic [1:0]  next_ans_cnt;
    logic        next_bad_seen;
    logic        next_lw_serviced;
    logic        next_good;
    logic        next_bad;
    logic        next_drv_clr;
    logic        next_warm;
    logic        next_started;
    logic        started;
    logic        bad_seen;
    logic        lw_serviced;
    logic        fail_hi;
    logic        rst_hi;
    logic        fail_hi_d;
    logic        rst_hi_d;
    logic        seq_end;
    logic        trig_ev;
    logic        ans_ev;
    logic        tmr_load;
    logic [7:0]  tmr_units;
    logic        tmr_expired;
    logic [3:0]  th_sum;

    qawd_win_timer u_timer (
        .clk     (clk),
        .rst_n   (rst_n),
        .load    (tmr_load),
        .units   (tmr_units),
        .expired (tmr_expired)
    );

    always_comb begin
        trig_ev = trig_rise && !trigger_or_qa_select;
        ans_ev  = answer_byte_pulse && trigger_or_qa_select;
        th_sum  = {1'b0, first_fail_threshold}
                + {1'b0, second_fail_threshold};
        fail_hi = failure_counter > {1'b0, first_fail_threshold};
        rst_hi  = (failure_counter > th_sum) && warm_reset_allow;
        next_state       = state;
        next_ans_cnt     = answer_count;
        next_bad_seen    = bad_seen;
        next_lw_serviced = lw_serviced;
        next_started     = 1'b1;
        next_good        = 1'b0;
        next_bad         = 1'b0;
        next_drv_clr     = fail_hi && !fail_hi_d;
        next_warm        = rst_hi && !rst_hi_d;
        flag_set         = 8'h00;
        flag_set[`QAWD_F_FAIL] = next_drv_clr;
        flag_set[`QAWD_F_RST]  = next_warm;
        seq_end  = 1'b0;
        tmr_load = !started;
        case (state)
            QAWD_LONG_WIN: begin
                if (trig_ev || ans_ev) begin
                    next_lw_serviced = 1'b1;
                end
                if (long_window_hold) begin
                    // Held: interval restarts and never elapses
                    tmr_load = 1'b1;
                end else if (tmr_expired) begin
                    if (lw_serviced) begin
                        next_state = QAWD_WIN1;
                        tmr_load   = 1'b1;
                    end else begin
                        next_warm = 1'b1;
                        flag_set[`QAWD_F_LW_EXP] = 1'b1;
                        tmr_load  = 1'b1;
                    end
                end
            end
            QAWD_WIN1: begin
                if (trig_ev) begin
                    flag_set[`QAWD_F_EARLY_TRG] = 1'b1;
                    next_bad_seen = 1'b1;
                    seq_end       = 1'b1;
                end else if (ans_ev) begin
                    if (!answer_byte_match) begin
                        flag_set[`QAWD_F_WRONG] = 1'b1;
                        next_bad_seen = 1'b1;
                    end
                    if (answer_count == `QAWD_LAST_ANS) begin
                        flag_set[`QAWD_F_EARLY_ANS] = 1'b1;
                        next_bad_seen = 1'b1;
                        seq_end       = 1'b1;
                    end else begin
                        next_ans_cnt = answer_count + 2'h1;
                    end
                end else if (tmr_expired) begin
                    next_state = QAWD_WIN2;
                    tmr_load   = 1'b1;
                end
            end
            QAWD_WIN2: begin
                if (trig_ev) begin
                    seq_end = 1'b1;
                end else if (ans_ev) begin
                    if (!answer_byte_match) begin
                        flag_set[`QAWD_F_WRONG] = 1'b1;
                        next_bad_seen = 1'b1;
                    end
                    if (answer_count == `QAWD_LAST_ANS) begin
                        seq_end = 1'b1;
                    end else begin
                        // Too few bytes arrived in window 1
                        flag_set[`QAWD_F_ORDER] = 1'b1;
                        next_bad_seen = 1'b1;
                        next_ans_cnt  = answer_count + 2'h1;
                    end
                end else if (tmr_expired) begin
                    flag_set[`QAWD_F_TIMEOUT] = 1'b1;
                    next_bad_seen = 1'b1;
                    seq_end       = 1'b1;
                end
            end
            default: begin
                next_state = QAWD_LONG_WIN;
                tmr_load   = 1'b1;
            end
        endcase
        if (seq_end) begin
            next_good     = !next_bad_seen;
            next_bad      = next_bad_seen;
            next_bad_seen = 1'b0;
            next_ans_cnt  = 2'h0;
            tmr_load      = 1'b1;
            if (return_to_long_window) begin
                next_state = QAWD_LONG_WIN;
            end else begin
                next_state = QAWD_WIN1;
            end
        end
        if (next_state == QAWD_LONG_WIN && state != QAWD_LONG_WIN) begin
            next_lw_serviced = 1'b0;
        end
        case (next_state)
            QAWD_WIN1: tmr_units = {1'b0, win1_cfg};
            QAWD_WIN2: tmr_units = {1'b0, win2_cfg};
            default:   tmr_units = long_win_cfg;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state                     <= QAWD_LONG_WIN;
            started                   <= 1'b0;
            answer_count              <= 2'h0;
            bad_seen                  <= 1'b0;
            lw_serviced               <= 1'b0;
            fail_hi_d                 <= 1'b0;
            rst_hi_d                  <= 1'b0;
            in_long_window            <= 1'b1;
            seq_good_pulse            <= 1'b0;
            seq_bad_pulse             <= 1'b0;
            output_drive_enable_clear <= 1'b0;
            warm_reset_req            <= 1'b0;
        end else begin
            state                     <= next_state;
            started                   <= next_started;
            answer_count              <= next_ans_cnt;
            bad_seen                  <= next_bad_seen;
            lw_serviced               <= next_lw_serviced;
            fail_hi_d                 <= fail_hi;
            rst_hi_d                  <= rst_hi;
            in_long_window            <= (next_state == QAWD_LONG_WIN);
            seq_good_pulse            <= next_good;
            seq_bad_pulse             <= next_bad;
            output_drive_enable_clear <= next_drv_clr;
            warm_reset_req            <= next_warm;
        end
    end

endmodule

// file: qawd_cs_chk.sv
// Concurrent checks on the watchdog control and status ports
`timescale 1ns/1ns
`include "qawd_regs.svh"
module qawd_cs_chk (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // Register port
    input  wire logic                    reg_wr_en,
    input  wire logic                    reg_rd_en,
    input  wire logic [`QAWD_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic [7:0]              reg_rdata,
    // Fail counter
    input  wire logic [3:0]              failure_counter,
    input  wire logic [2:0]              first_fail_threshold,
    input  wire logic [2:0]              second_fail_threshold,
    input  wire logic                    warm_reset_allow,
    // Configuration and status
    input  wire logic                    long_window_hold,
    input  wire logic                    trigger_or_qa_select,
    input  wire logic                    return_to_long_window,
    input  wire logic [1:0]              question_feedback_cfg,
    input  wire logic [1:0]              question_lfsr_select,
    input  wire logic [3:0]              question_seed,
    input  wire logic                    in_long_window,
    input  wire logic                    seq_good_pulse,
    input  wire logic                    seq_bad_pulse,
    input  wire logic                    output_drive_enable_clear,
    input  wire logic                    warm_reset_req
);
    logic [1:0] rcnt;
    logic [1:0] next_rcnt;
    logic       fail_over;
    logic       sum_over;

    assign fail_over = failure_counter > {1'b0, first_fail_threshold};
    assign sum_over  = {1'b0, failure_counter} >
                       ({2'h0, first_fail_threshold} +
                        {2'h0, second_fail_threshold});

    // Wait out the internal reset synchroniser
    always_comb next_rcnt = (rcnt == 2'h3) ? rcnt : rcnt + 2'h1;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            rcnt <= 2'h0;
        else
            rcnt <= next_rcnt;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || rcnt != 2'h3);

    sequence s_seq_end;
        seq_good_pulse || seq_bad_pulse;
    endsequence
    sequence s_mode_wr;
        reg_wr_en && reg_addr == `QAWD_MODE_OFS;
    endsequence

    a_hold_write: assert property (
        s_mode_wr |=> long_window_hold == $past(reg_wdata[`QAWD_HOLD_BIT]))
        else $error("hold bit did not follow the write");
    a_hold_stays: assert property (
        long_window_hold && in_long_window |=> in_long_window)
        else $error("left the long window while held");
    a_select_locked: assert property (
        !in_long_window |=> $stable(trigger_or_qa_select))
        else $error("mode select changed outside the long window");
    a_qcfg_locked: assert property (
        !in_long_window |=> $stable({question_feedback_cfg,
                                     question_lfsr_select, question_seed}))
        else $error("question config changed outside the long window");
    a_return_end: assert property (
        s_seq_end |=> in_long_window == $past(return_to_long_window))
        else $error("wrong state after sequence end");
    a_drive_clear: assert property (
        $rose(fail_over) |-> ##[1:2] output_drive_enable_clear)
        else $error("drive enable not cleared past first threshold");
    a_warm_sum: assert property (
        $rose(sum_over) && warm_reset_allow |-> ##[1:2] warm_reset_req)
        else $error("no warm reset past threshold sum");
    a_qcfg_readback: assert property (
        reg_rd_en && reg_addr == `QAWD_QCFG_OFS |=> reg_rdata ==
        $past({question_feedback_cfg, question_lfsr_select, question_seed}))
        else $error("question config read mismatch");
    a_mode_readback: assert property (
        reg_rd_en && reg_addr == `QAWD_MODE_OFS |=> reg_rdata[2:0] ==
        $past({long_window_hold, trigger_or_qa_select,
               return_to_long_window}))
        else $error("mode read mismatch");
endmodule

bind qawd_control_status qawd_cs_chk u_chk (
    .clk, .rstn, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .failure_counter, .first_fail_threshold, .second_fail_threshold,
    .warm_reset_allow, .long_window_hold, .trigger_or_qa_select,
    .return_to_long_window, .question_feedback_cfg, .question_lfsr_select,
    .question_seed, .in_long_window, .seq_good_pulse, .seq_bad_pulse,
    .output_drive_enable_clear, .warm_reset_req
);

// file: qawd_host.sv
// Host model that services the watchdog with answers and triggers
`timescale 1ns/1ns
module qawd_host (
    // Clock
    input  wire logic clk,
    // Commands from the bench
    input  wire logic ans_req,
    input  wire logic ans_ok,
    input  wire logic trg_req,
    // Servicing events
    output logic      trigger_pin,
    output logic      answer_byte_pulse,
    output logic      answer_byte_match
);
    logic [2:0] trg_cnt;

    initial begin
        trg_cnt = 3'h0;
        answer_byte_pulse = 1'b0;
        answer_byte_match = 1'b0;
    end

    // Match means nothing without the pulse, so it toggles then
    always @(posedge clk) begin
        answer_byte_pulse <= ans_req;
        answer_byte_match <= ans_req ? ans_ok : !answer_byte_match;
        trg_cnt <= trg_req ? 3'h4 : trg_cnt - {2'h0, trg_cnt != 3'h0};
    end
    assign trigger_pin = trg_cnt != 3'h0;
endmodule

// file: qawd_pkg.sv
// Types shared by the watchdog control and status block
package qawd_pkg;

    typedef enum logic [1:0] {
        QAWD_LONG_WIN = 2'h0,
        QAWD_WIN1     = 2'h1,
        QAWD_WIN2     = 2'h3
    } qawd_state_t;

endpackage

// file: qawd_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef QAWD_REGS_SVH
`define QAWD_REGS_SVH

`define QAWD_ADDR_W      11
`define QAWD_MODE_OFS    11'h406
`define QAWD_QCFG_OFS    11'h407
`define QAWD_ERR_OFS     11'h408

`define QAWD_MODE_RST    8'h02
`define QAWD_QCFG_RST    8'h0A
`define QAWD_ERR_RST     8'h00

`define QAWD_HOLD_BIT    2
`define QAWD_SEL_BIT     1
`define QAWD_RET_BIT     0
`define QAWD_RSV_MSB     7
`define QAWD_RSV_LSB     3

`define QAWD_FDBK_MSB    7
`define QAWD_FDBK_LSB    6
`define QAWD_LFSR_MSB    5
`define QAWD_LFSR_LSB    4
`define QAWD_SEED_MSB    3
`define QAWD_SEED_LSB    0

`define QAWD_F_RST       7
`define QAWD_F_FAIL      6
`define QAWD_F_WRONG     5
`define QAWD_F_ORDER     4
`define QAWD_F_EARLY_ANS 3
`define QAWD_F_EARLY_TRG 2
`define QAWD_F_TIMEOUT   1
`define QAWD_F_LW_EXP    0

`define QAWD_CLK_NS      4
`define QAWD_TICK_NS     1000
`define QAWD_TICK_CYC    (`QAWD_TICK_NS / `QAWD_CLK_NS)
`define QAWD_LAST_ANS    2'h3

`endif

// file: qawd_sync.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module qawd_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Data
    input  wire logic d,
    output logic      q
);

    logic s1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            q  <= 1'b0;
        end else begin
            s1 <= d;
            q  <= s1;
        end
    end

endmodule

// file: qawd_win_timer.sv
// Window timer: counts (units + 1) ticks after a load, then pulses
`timescale 1ns/1ns
`include "qawd_regs.svh"
module qawd_win_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       load,
    input  wire logic [7:0] units,
    // Status
    output logic            expired
);

    localparam logic [7:0] TICK_LAST = 8'(`QAWD_TICK_CYC - 1);

    logic [7:0] pre;
    logic [7:0] left;
    logic       running;
    logic [7:0] next_pre;
    logic [7:0] next_left;
    logic       next_running;
    logic       next_expired;
    logic       tick;

    always_comb begin
        tick         = running && (pre == TICK_LAST);
        next_pre     = pre;
        next_left    = left;
        next_running = running;
        next_expired = 1'b0;
        if (load) begin
            next_pre     = 8'h00;
            next_left    = units;
            next_running = 1'b1;
        end else if (running) begin
            next_pre = tick ? 8'h00 : pre + 8'h01;
            if (tick) begin
                if (left == 8'h00) begin
                    next_running = 1'b0;
                    next_expired = 1'b1;
                end else begin
                    next_left = left - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre     <= 8'h00;
            left    <= 8'h00;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            pre     <= next_pre;
            left    <= next_left;
            running <= next_running;
            expired <= next_expired;
        end
    end

endmodule

// file: tb_qa_watchdog_control_status.sv
// Self-checking bench for the watchdog control and status block
`timescale 1ns/1ns
`include "qawd_regs.svh"
module tb_qa_watchdog_control_status;
    logic                    clk, rstn, reg_wr_en, reg_rd_en;
    logic [`QAWD_ADDR_W-1:0] reg_addr;
    logic [7:0]              reg_wdata, reg_rdata, rd_val;
    logic [3:0]              failure_counter;
    logic [2:0]              first_fail_threshold, second_fail_threshold;
    logic                    warm_reset_allow, ans_req, ans_ok, trg_req;
    logic                    trigger_pin, answer_byte_pulse, answer_byte_match;
    logic                    long_window_hold, trigger_or_qa_select;
    logic                    return_to_long_window, in_long_window;
    logic [1:0]              question_feedback_cfg, question_lfsr_select;
    logic [3:0]              question_seed;
    logic [1:0]              answer_count;
    logic                    seq_good_pulse, seq_bad_pulse, warm_reset_req;
    logic                    output_drive_enable_clear;
    int                      n_errors, checked, i;

    qawd_control_status dut (
        .clk, .rstn, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
        .reg_rdata, .long_win_cfg(8'h01), .win1_cfg(7'h00), .win2_cfg(7'h00),
        .failure_counter, .first_fail_threshold, .second_fail_threshold,
        .warm_reset_allow, .trigger_pin, .answer_byte_pulse,
        .answer_byte_match, .long_window_hold, .trigger_or_qa_select,
        .return_to_long_window, .question_feedback_cfg,
        .question_lfsr_select, .question_seed, .in_long_window,
        .answer_count, .seq_good_pulse, .seq_bad_pulse,
        .output_drive_enable_clear, .warm_reset_req
    );
    qawd_host u_host (
        .clk, .ans_req, .ans_ok, .trg_req, .trigger_pin,
        .answer_byte_pulse, .answer_byte_match
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk8(input string n, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic wr(input logic [`QAWD_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(posedge clk);
        #1;
        reg_wr_en = 1'b0;
    endtask
    task automatic rdchk(input logic [`QAWD_ADDR_W-1:0] a,
                         input logic [7:0] m, e, input string n);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge clk);
        #1;
        reg_rd_en = 1'b0;
        rd_val = reg_rdata;
        chk8(n, e, rd_val & m);
    endtask
    // One answer byte or one trigger through the host
    task automatic svc(input logic trg, ok);
        @(posedge clk);
        #1;
        trg_req = trg;
        ans_req = !trg;
        ans_ok = ok;
        @(posedge clk);
        #1;
        trg_req = 1'b0;
        ans_req = 1'b0;
    endtask
    function automatic logic seen(input int s);
        case (s)
            0: seen = in_long_window;
            1: seen = !in_long_window;
            2: seen = seq_good_pulse;
            3: seen = seq_bad_pulse;
            4: seen = warm_reset_req;
            default: seen = output_drive_enable_clear;
        endcase
    endfunction
    task automatic wait_on(input int s, lim, input string n);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < lim && hit !== 1'b1; k++) begin
            @(posedge clk);
            #1;
            hit = seen(s);
        end
        chk1(n, 1'b1, hit);
    endtask
    task automatic done(input string n);
        $display("test %s done, mismatches so far %0d", n, n_errors);
    endtask
    task automatic end_of_test;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #80000;
        n_errors++;
        end_of_test();
    end

    initial begin
        {rstn, reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
        {failure_counter, first_fail_threshold} = '0;
        {second_fail_threshold, warm_reset_allow} = '0;
        {ans_req, ans_ok, trg_req} = '0;
        repeat (8) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge clk);
        rdchk(`QAWD_MODE_OFS, 8'hFF, `QAWD_MODE_RST, "mode");
        rdchk(`QAWD_QCFG_OFS, 8'hFF, `QAWD_QCFG_RST, "qcfg");
        rdchk(`QAWD_ERR_OFS, 8'hFF, `QAWD_ERR_RST, "flags");
        rdchk(11'h400, 8'hFF, 8'h00, "unmapped");
        done("reset");
        wr(`QAWD_QCFG_OFS, 8'hE5);
        rdchk(`QAWD_QCFG_OFS, 8'hFF, 8'hE5, "qcfg");
        wr(`QAWD_MODE_OFS, 8'hFE);
        rdchk(`QAWD_MODE_OFS, 8'hFF, 8'hFE, "mode");
        repeat (700) @(posedge clk);
        chk1("held", 1'b1, in_long_window);
        done("hold");
        wr(`QAWD_MODE_OFS, 8'h02);
        wait_on(4, 600, "expiry reset");
        rdchk(`QAWD_ERR_OFS, 8'hFF, 8'h01, "flags");
        wr(`QAWD_ERR_OFS, 8'h02);
        rdchk(`QAWD_ERR_OFS, 8'hFF, 8'h01, "flags");
        wr(`QAWD_ERR_OFS, 8'h01);
        rdchk(`QAWD_ERR_OFS, 8'hFF, 8'h00, "flags");
        done("expiry");
        svc(1'b0, 1'b1);
        wait_on(1, 600, "left window");
        wr(`QAWD_QCFG_OFS, 8'h00);
        wr(`QAWD_MODE_OFS, 8'h00);
        rdchk(`QAWD_QCFG_OFS, 8'hFF, 8'hE5, "qcfg");
        rdchk(`QAWD_MODE_OFS, 8'hFF, 8'h02, "mode");
        for (i = 0; i < 3; i++)
            svc(1'b0, 1'b1);
        repeat (280) @(posedge clk);
        chk8("count", 8'h03, {6'h00, answer_count});
        svc(1'b0, 1'b1);
        wait_on(2, 20, "good end");
        rdchk(`QAWD_ERR_OFS, 8'hFF, 8'h00, "flags");
        done("good answers");
        for (i = 0; i < 4; i++)
            svc(1'b0, i != 1);
        wait_on(3, 20, "early end");
        repeat (280) @(posedge clk);
        svc(1'b0, 1'b1);
        wait_on(3, 600, "timeout end");
        rdchk(`QAWD_ERR_OFS, 8'hFF, 8'h3A, "flags");
        wr(`QAWD_ERR_OFS, 8'hFF);
        rdchk(`QAWD_ERR_OFS, 8'hFF, 8'h00, "flags");
        done("answer errors");
        wr(`QAWD_MODE_OFS, 8'h03);
        wait_on(0, 700, "returned");
        wr(`QAWD_MODE_OFS, 8'h00);
        rdchk(`QAWD_MODE_OFS, 8'hFF, 8'h00, "mode");
        svc(1'b1, 1'b0);
        wait_on(1, 600, "left window");
        svc(1'b1, 1'b0);
        repeat (10) @(posedge clk);
        rdchk(`QAWD_ERR_OFS, 8'h04, 8'h04, "flags");
        wr(`QAWD_ERR_OFS, 8'hFF);
        done("trigger");
        first_fail_threshold = 3'h2;
        second_fail_threshold = 3'h3;
        warm_reset_allow = 1'b1;
        failure_counter = 4'h3;
        wait_on(5, 10, "drive clear");
        failure_counter = 4'h6;
        wait_on(4, 10, "warm reset");
        rdchk(`QAWD_ERR_OFS, 8'hC0, 8'hC0, "flags");
        done("fail count");
        end_of_test();
    end
endmodule
